/* File: osep_pkg.sv */
// osep_pkg: register map, field positions and state of the output
// scaling and event pin block.
// assumes a 32-bit APB slave with byte addresses on an 8-bit bus.
package osep_pkg;
  // ********************************
  // register offsets
  // ********************************
  localparam logic [7:0] OFF_SHIFT_A = 8'h00;
  localparam logic [7:0] OFF_SHIFT_B = 8'h04;
  localparam logic [7:0] OFF_EVCFG = 8'h08;
  localparam logic [7:0] OFF_LIMIT0 = 8'h0C;
  localparam logic [7:0] OFF_EVSTAT = 8'h24;
  localparam logic [7:0] OFF_MSQ = 8'h28;
  localparam logic [7:0] OFF_OUT0 = 8'h2C;
  localparam logic [7:0] OFF_OUT_END = 8'h48;
  localparam int NUM_LIM = 6;
  localparam int NUM_OUT = 7;
  // ********************************
  // field positions
  // ********************************
  localparam int POS_VOLT = 0;
  localparam int POS_CUR = 8;
  localparam int POS_PWR = 16;
  localparam int POS_CAL = 24;
  localparam int POS_ROUTE_A = 16;
  localparam int POS_ROUTE_B = 20;
  localparam int POS_MAN_A = 14;
  localparam int POS_MAN_B = 15;
  localparam int POS_CLR = 8;
  localparam int POS_LATCH = 4;
  localparam int POS_TEST = 0;
  // event order used inside the block
  localparam int EV_SAG = 0;
  localparam int EV_SURGE = 1;
  localparam int EV_OC = 2;
  localparam int EV_OP = 3;
  // output order on the raw and scaled value arrays
  localparam int IX_VRMS = 0;
  localparam int IX_IRMS1 = 1;
  localparam int IX_IRMS2 = 2;
  localparam int IX_PACT1 = 3;
  localparam int IX_PREA1 = 4;
  localparam int IX_PACT2 = 5;
  localparam int IX_PREA2 = 6;
  // limit order
  localparam int LIM_SAG = 0;
  localparam int LIM_SURGE = 1;
  localparam int LIM_OC1 = 2;
  localparam int LIM_OP1 = 3;
  localparam int LIM_OC2 = 4;
  localparam int LIM_OP2 = 5;
  // ********************************
  // reset values and state
  // ********************************
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  typedef struct packed {
    logic [23:0] shift_a;
    logic [15:0] shift_b;
    logic [3:0] route_a;
    logic [3:0] route_b;
    logic man_a;
    logic man_b;
    logic [3:0] latch_en;
    logic [3:0] test_en;
    logic [NUM_LIM-1:0][31:0] limit;
    logic [7:0] cal_fail;
    logic [3:0] cond;
    logic [3:0] evt;
    logic [NUM_OUT-1:0][31:0] out;
    logic alert_a;
    logic alert_b;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } osep_state_s;
endpackage : osep_pkg

/* File: osep_shift.sv */
// osep_shift: divides one computed value by two to the shift count.
// assumes the count is stable while the result is sampled.
`timescale 1ns/1ps
module osep_shift #(
  parameter int DATA_W = 32,
  parameter bit ARITH = 1'b0
) (
  input wire logic [DATA_W-1:0] val_in,
  input wire logic [7:0] shift_cnt,
  output logic [DATA_W-1:0] val_out
);
  // signed powers keep their sign, rms values shift in zeros
  always_comb begin
    if (ARITH) begin
      val_out = $signed(val_in) >>> shift_cnt; // R22
    end else begin
      val_out = val_in >> shift_cnt; // R01
    end
  end
endmodule : osep_shift

/* File: osep_msq.sv */
// osep_msq: trailing mean square of the voltage samples.
// assumes one sample per data-ready pulse; window is 2**WIN_LOG2.
`timescale 1ns/1ps
module osep_msq #(
  parameter int WIN_LOG2 = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sample_valid,
  input wire logic [15:0] sample,
  output logic [31:0] msq,
  output logic msq_valid
);
  localparam int DEPTH = 2 ** WIN_LOG2;
  localparam int SW = 32 + WIN_LOG2;
  typedef struct packed {
    logic [DEPTH-1:0][31:0] ring;
    logic [WIN_LOG2-1:0] idx;
    logic [SW-1:0] sum;
    logic [31:0] msq;
    logic valid;
  } osep_msq_s;
  osep_msq_s st;
  osep_msq_s next_st;
  logic signed [31:0] sq;
  assign sq = $signed(sample) * $signed(sample);
  // running sum: add newest square, drop the one leaving the window
  always_comb begin
    next_st = st;
    next_st.valid = sample_valid;
    if (sample_valid) begin
      next_st.ring[st.idx] = sq;
      next_st.idx = st.idx + 1'b1;
      next_st.sum = st.sum + SW'(sq) - SW'(st.ring[st.idx]); // R13
      next_st.msq = next_st.sum[SW-1:WIN_LOG2];
    end
  end
  // power of two window makes the mean a plain shift
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign msq = st.msq;
  assign msq_valid = st.valid;
  msq_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
    sample_valid |=> msq_valid ##1 (msq_valid == $past(sample_valid)))
    else $error("mean square not updated after sample"); // R13
endmodule : osep_msq

/* File: osep_top.sv */
// osep_top: output range scaling, event limits and event pins.
// assumes APB master on CLK_SYS, raw values valid with COMP_DONE and
// voltage samples valid with DATA_READY.
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
// Behaviour
// R01: right-shift each output by its range count
// R02: one power count scales active and reactive
// R03: first range: ch1_power_shift, ch1_current_shift, voltage bytes
// R04: second range: ch2_power_shift, ch2_current_shift, low byte empty
// R05: unused range bits read zero, reset zero
// R06: host picks counts avoiding overflow, keeping resolution
// R07: two event pins: unmapped, mapped or manual
// R08: any mapped active event drives pin
// R09: manual level only when nothing mapped
// R10: six limits compared in output units; sag and surge limits compare against the unscaled mean square
// R11: over-current and over-power checked each cycle
// R12: sag and surge detected within one line
// R13: trailing mean square over half line cycle
// R14: compare mean square at each data-ready
// R15: mapped flagged event drives pin high
// R16: eight calibration fail bits in 31-24
// R17: successful calibration clears its status bit
// R18: one route bit per event per pin
// R19: manual level bit per pin, default low
// R20: latch enable holds event until cleared
// R21: writing clear bit deasserts latched event
// R22: rms shifts logical, power shifts arithmetic
// R23: limits compare against scaled outputs; sag and surge limits compare against the unscaled mean square
module osep_top #(
  parameter int WIN_LOG2 = 4
) (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic COMP_DONE,
  input wire logic [6:0][31:0] RAW_VAL,
  input wire logic DATA_READY,
  input wire logic [15:0] V_SAMPLE,
  input wire logic CAL_DONE,
  input wire logic [7:0] CAL_TARGET,
  input wire logic CAL_PASS,
  output logic [6:0][31:0] OUT_VAL,
  output logic ALERT_OUT_A,
  output logic ALERT_OUT_B
);
  // ********************************
  // state and helpers
  // ********************************
  osep_pkg::osep_state_s st;
  osep_pkg::osep_state_s next_st;
  logic [6:0][7:0] cnt;
  logic [6:0][31:0] sc;
  logic [31:0] msq;
  logic msq_valid;
  logic acc;
  logic wr_go;
  logic hit;
  logic [31:0] rdata;
  logic [31:0] evcfg_word;
  logic [7:0] lim_off;
  logic [7:0] out_off;
  logic [2:0] lim_ix;
  logic [2:0] out_ix;
  logic [3:0] clr;
  logic [3:0] raw;

  // latch and test fields hold surge, sag, op, oc from the top bit;
  // swapping pairs maps them to the internal event order both ways
  function automatic logic [3:0] pair_swap(input logic [3:0] x);
    pair_swap = {x[1], x[0], x[3], x[2]};
  endfunction : pair_swap

  // ********************************
  // shift counts and scalers
  // ********************************
  // both power outputs of a channel take the same count
  always_comb begin
    cnt[osep_pkg::IX_VRMS] = st.shift_a[osep_pkg::POS_VOLT +: 8]; // R03
    cnt[osep_pkg::IX_IRMS1] = st.shift_a[osep_pkg::POS_CUR +: 8];
    cnt[osep_pkg::IX_PACT1] = st.shift_a[osep_pkg::POS_PWR +: 8]; // R02
    cnt[osep_pkg::IX_PREA1] = st.shift_a[osep_pkg::POS_PWR +: 8];
    cnt[osep_pkg::IX_IRMS2] = st.shift_b[7:0]; // R04
    cnt[osep_pkg::IX_PACT2] = st.shift_b[15:8]; // R02
    cnt[osep_pkg::IX_PREA2] = st.shift_b[15:8];
  end

  // one scaler per output; powers are signed and shift arithmetically
  for (genvar g = 0; g < osep_pkg::NUM_OUT; g++) begin : g_scale
    osep_shift #(
      .DATA_W(32),
      .ARITH(g >= osep_pkg::IX_PACT1)
    ) u_shift (
      .val_in(RAW_VAL[g]),
      .shift_cnt(cnt[g]),
      .val_out(sc[g])
    );
  end

  // trailing mean square feeds sag and surge, and reads back at OFF_MSQ
  osep_msq #(
    .WIN_LOG2(WIN_LOG2)
  ) u_msq (
    .clk(CLK_SYS),
    .resetn(RESETN),
    .sample_valid(DATA_READY),
    .sample(V_SAMPLE),
    .msq(msq),
    .msq_valid(msq_valid)
  );

  // ********************************
  // apb decode and read data
  // ********************************
  // answer comes one cycle into the access phase
  assign acc = PSEL & PENABLE & ~st.pready;
  assign wr_go = PSEL & PENABLE & st.pready & PWRITE;
  assign lim_off = PADDR - osep_pkg::OFF_LIMIT0;
  assign out_off = PADDR - osep_pkg::OFF_OUT0;
  assign lim_ix = lim_off[4:2];
  assign out_ix = out_off[4:2];

  // event config word; clear bits always read back as zero
  always_comb begin
    evcfg_word = osep_pkg::RST_WORD;
    evcfg_word[osep_pkg::POS_CAL +: 8] = st.cal_fail; // R16
    evcfg_word[osep_pkg::POS_ROUTE_A +: 4] = st.route_a; // R18
    evcfg_word[osep_pkg::POS_ROUTE_B +: 4] = st.route_b;
    evcfg_word[osep_pkg::POS_MAN_A] = st.man_a; // R19
    evcfg_word[osep_pkg::POS_MAN_B] = st.man_b;
    evcfg_word[osep_pkg::POS_LATCH +: 4] = pair_swap(st.latch_en);
    evcfg_word[osep_pkg::POS_TEST +: 4] = pair_swap(st.test_en);
  end

  // read mux; unmapped addresses answer with an error and zero data
  always_comb begin
    rdata = osep_pkg::RST_WORD;
    hit = 1'b1;
    if (PADDR == osep_pkg::OFF_SHIFT_A) begin
      rdata = {8'h00, st.shift_a}; // R05
    end else if (PADDR == osep_pkg::OFF_SHIFT_B) begin
      rdata = {8'h00, st.shift_b, 8'h00}; // R05
    end else if (PADDR == osep_pkg::OFF_EVCFG) begin
      rdata = evcfg_word;
    end else if (PADDR >= osep_pkg::OFF_LIMIT0 &&
                 PADDR < osep_pkg::OFF_EVSTAT && PADDR[1:0] == 2'h0) begin
      rdata = st.limit[lim_ix];
    end else if (PADDR == osep_pkg::OFF_EVSTAT) begin
      rdata = {24'h000000, st.evt, st.cond};
    end else if (PADDR == osep_pkg::OFF_MSQ) begin
      rdata = msq;
    end else if (PADDR >= osep_pkg::OFF_OUT0 &&
                 PADDR < osep_pkg::OFF_OUT_END && PADDR[1:0] == 2'h0) begin
      rdata = st.out[out_ix];
    end else begin
      hit = 1'b0;
    end
  end

  // clear strobes in internal order, taken from a field of oc, op, surge, sag from the top
  always_comb begin
    clr = 4'h0;
    if (wr_go && PADDR == osep_pkg::OFF_EVCFG) begin
      clr[osep_pkg::EV_SAG] = PWDATA[osep_pkg::POS_CLR]; // R21
      clr[osep_pkg::EV_SURGE] = PWDATA[osep_pkg::POS_CLR + 1];
      clr[osep_pkg::EV_OP] = PWDATA[osep_pkg::POS_CLR + 2];
      clr[osep_pkg::EV_OC] = PWDATA[osep_pkg::POS_CLR + 3];
    end
  end

  // ********************************
  // next state
  // ********************************
  always_comb begin
    next_st = st;
    // register writes take effect at the edge that ends the access
    if (wr_go) begin
      if (PADDR == osep_pkg::OFF_SHIFT_A) begin
        next_st.shift_a = PWDATA[23:0]; // R03
      end else if (PADDR == osep_pkg::OFF_SHIFT_B) begin
        next_st.shift_b = PWDATA[23:8]; // R04
      end else if (PADDR == osep_pkg::OFF_EVCFG) begin
        next_st.route_a = PWDATA[osep_pkg::POS_ROUTE_A +: 4]; // R18
        next_st.route_b = PWDATA[osep_pkg::POS_ROUTE_B +: 4];
        next_st.man_a = PWDATA[osep_pkg::POS_MAN_A]; // R19
        next_st.man_b = PWDATA[osep_pkg::POS_MAN_B];
        next_st.latch_en = pair_swap(PWDATA[osep_pkg::POS_LATCH +: 4]);
        next_st.test_en = pair_swap(PWDATA[osep_pkg::POS_TEST +: 4]);
      end else if (PADDR >= osep_pkg::OFF_LIMIT0 &&
                   PADDR < osep_pkg::OFF_EVSTAT &&
                   PADDR[1:0] == 2'h0) begin
        next_st.limit[lim_ix] = PWDATA; // R10
      end
    end
    // scaled outputs move only once per computation cycle
    if (COMP_DONE) begin
      next_st.out = sc; // R01
      // over checks use the freshly scaled values, in output units
      next_st.cond[osep_pkg::EV_OC] = // R11 R23
        (sc[osep_pkg::IX_IRMS1] > st.limit[osep_pkg::LIM_OC1]) |
        (sc[osep_pkg::IX_IRMS2] > st.limit[osep_pkg::LIM_OC2]);
      next_st.cond[osep_pkg::EV_OP] = // R10
        ($signed(sc[osep_pkg::IX_PACT1]) >
         $signed(st.limit[osep_pkg::LIM_OP1])) |
        ($signed(sc[osep_pkg::IX_PACT2]) >
         $signed(st.limit[osep_pkg::LIM_OP2]));
    end
    // sag and surge follow every sample, no hold register needed
    if (msq_valid) begin
      next_st.cond[osep_pkg::EV_SAG] = // R14 R12
        msq < st.limit[osep_pkg::LIM_SAG];
      next_st.cond[osep_pkg::EV_SURGE] =
        msq > st.limit[osep_pkg::LIM_SURGE];
    end
    // a latched event survives a clear that meets a new set
    raw = next_st.cond | st.test_en;
    for (int i = 0; i < 4; i++) begin
      if (st.latch_en[i]) begin
        next_st.evt[i] = raw[i] | (st.evt[i] & ~clr[i]); // R20 R21
      end else begin
        next_st.evt[i] = raw[i];
      end
    end
    // mapped events override the manual level of a pin
    if (st.route_a != 4'h0) begin
      next_st.alert_a = |(next_st.evt & st.route_a); // R08 R15
    end else begin
      next_st.alert_a = st.man_a; // R09
    end
    if (st.route_b != 4'h0) begin
      next_st.alert_b = |(next_st.evt & st.route_b); // R07
    end else begin
      next_st.alert_b = st.man_b; // R09
    end
    // only targeted results change; a pass clears the fail bit
    if (CAL_DONE) begin
      for (int i = 0; i < 8; i++) begin
        if (CAL_TARGET[i]) begin
          next_st.cal_fail[i] = ~CAL_PASS; // R16 R17
        end
      end
    end
    // apb answer
    next_st.pready = acc;
    next_st.pslverr = acc & ~hit;
    next_st.prdata = (acc & ~PWRITE & hit) ? rdata : osep_pkg::RST_WORD;
  end

  // every field starts at zero, pins low
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      st <= '0; // R05
    end else begin
      st <= next_st;
    end
  end

  assign PRDATA = st.prdata;
  assign PREADY = st.pready;
  assign PSLVERR = st.pslverr;
  assign OUT_VAL = st.out;
  assign ALERT_OUT_A = st.alert_a;
  assign ALERT_OUT_B = st.alert_b;

  // ********************************
  // checks
  // ********************************
  sequence rd_done_s(logic [7:0] a);
    PSEL && PENABLE && !PWRITE && PADDR == a && !PREADY ##1 PREADY;
  endsequence

  sequence clr_wr_s(int e);
    wr_go && clr[e] && !raw[e];
  endsequence

  range_a_top_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_done_s(osep_pkg::OFF_SHIFT_A) |-> PRDATA[31:24] == 8'h00)
    else $error("range a top byte not zero"); // R05

  range_b_low_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rd_done_s(osep_pkg::OFF_SHIFT_B) |->
      PRDATA[7:0] == 8'h00 && PRDATA[31:24] == 8'h00)
    else $error("range b unused bits not zero"); // R04

  volt_scale_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    COMP_DONE |=> OUT_VAL[osep_pkg::IX_VRMS] ==
      ($past(RAW_VAL[osep_pkg::IX_VRMS]) >> $past(st.shift_a[7:0])))
    else $error("voltage not shifted by its count"); // R01

  power_same_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    COMP_DONE |=> OUT_VAL[osep_pkg::IX_PREA1] ==
      32'($signed($past(RAW_VAL[osep_pkg::IX_PREA1])) >>>
      $past(st.shift_a[23:16])))
    else $error("reactive power scaled differently"); // R02

  out_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    !COMP_DONE |=> $stable(OUT_VAL))
    else $error("outputs moved outside computation"); // R11

  manual_pin_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    st.route_a == 4'h0 |=> ALERT_OUT_A == $past(st.man_a))
    else $error("manual level not on unmapped pin"); // R09

  mapped_pin_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (st.route_b != 4'h0) && ((next_st.evt & st.route_b) != 4'h0)
    |=> ALERT_OUT_B)
    else $error("mapped event did not raise pin"); // R08

  latch_keep_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    st.latch_en[osep_pkg::EV_OC] && st.evt[osep_pkg::EV_OC] &&
    !clr[osep_pkg::EV_OC] |=> st.evt[osep_pkg::EV_OC])
    else $error("latched event dropped without clear"); // R20

  clear_drop_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    clr_wr_s(osep_pkg::EV_OC) |=> !st.evt[osep_pkg::EV_OC])
    else $error("cleared event still active"); // R21

  sag_flag_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    msq_valid && msq < st.limit[osep_pkg::LIM_SAG]
    |=> st.cond[osep_pkg::EV_SAG] && (ALERT_OUT_B || !$past(st.route_b[0])))
    else $error("sag not flagged at data ready"); // R14

  cal_pass_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    CAL_DONE && CAL_PASS |=> (st.cal_fail & $past(CAL_TARGET)) == 8'h00)
    else $error("passed calibration left fail bit"); // R17

  apb_answer_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
    else $error("apb answer not one cycle late"); // R10
endmodule : osep_top

/* File: osep_host_mdl.sv */
// osep_host_mdl: apb host standing in for the controlling processor.
// assumes a slave on the same clock; only the bench watchdog ends a hang.
`timescale 1ns/1ps
module osep_host_mdl (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ********************************
  // idle bus and one transfer
  // ********************************
  // idle lines carry junk so a slave cannot lean on stale values
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'hA5;
    pwdata = 32'h5A5A_5A5A;
  end

  // request held until pready is seen high; host data are the bench's
  // shift, limit and event config words, passed through untouched
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e,
      output bit ok);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    ok = (pready === 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : osep_host_mdl

/* File: output_scaling_and_event_pins_tb.sv */
// output_scaling_and_event_pins_tb: self-checking bench for osep_top.
// assumes osep_host_mdl as apb host and one 10 MHz clock.
`timescale 1ns/1ps
module output_scaling_and_event_pins_tb;
  // ********************************
  // signals and model state
  // ********************************
  logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr;
  logic comp_done, data_ready, cal_done, cal_pass, alert_a, alert_b;
  logic [7:0] paddr, cal_target;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0][31:0] raw_val, out_val;
  logic [15:0] v_sample;
  logic err;
  bit ok;
  int fails, total_checks, seed;
  longint sq[$] = '{0, 0, 0, 0};

  // small window keeps the mean square test short
  osep_top #(.WIN_LOG2(2)) dut (.CLK_SYS(clk_sys), .RESETN(resetn),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .COMP_DONE(comp_done), .RAW_VAL(raw_val),
    .DATA_READY(data_ready), .V_SAMPLE(v_sample), .CAL_DONE(cal_done),
    .CAL_TARGET(cal_target), .CAL_PASS(cal_pass), .OUT_VAL(out_val),
    .ALERT_OUT_A(alert_a), .ALERT_OUT_B(alert_b));
  osep_host_mdl host (.clk(clk_sys), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // ********************************
  // tasks
  // ********************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    host.xfer(w, a, d, rd, err, ok);
    if (!ok) begin
      fails++;
      $display("ERROR t=%0t no answer at %h", $time, a);
    end
  endtask : acc

  // pins settle a few clocks after the cause; sample off the edge
  task automatic pins(input logic ea, input logic eb);
    repeat (4) @(posedge clk_sys);
    #10;
    chk({30'h0, alert_a, alert_b}, {30'h0, ea, eb}, "event pins");
  endtask : pins

  task automatic comp(input logic [6:0][31:0] v);
    @(posedge clk_sys);
    comp_done <= 1'b1;
    raw_val <= v;
    @(posedge clk_sys);
    comp_done <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #10;
  endtask : comp

  task automatic samp(input logic [15:0] x);
    longint xs;
    xs = $signed(x);
    @(posedge clk_sys);
    data_ready <= 1'b1;
    v_sample <= x;
    @(posedge clk_sys);
    data_ready <= 1'b0;
    v_sample <= ~x;
    sq.push_back(xs * xs);
    void'(sq.pop_front());
  endtask : samp

  task automatic cal(input logic [7:0] t, input logic p);
    @(posedge clk_sys);
    cal_done <= 1'b1;
    cal_target <= t;
    cal_pass <= p;
    @(posedge clk_sys);
    cal_done <= 1'b0;
  endtask : cal

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // ********************************
  // clock, watchdog and tests
  // ********************************
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // whole run is under 3000 clocks; this allows many times that
  initial begin
    #2_000_000;
    fails++;
    $display("ERROR t=%0t watchdog expired", $time);
    final_report();
  end

  initial begin : main
    int v, c1, c2, p1, p2;
    int sh[7];
    logic [31:0] e;
    logic signed [31:0] s;
    logic [6:0][31:0] rv;
    longint m;
    seed = 77346;
    resetn = 1'b0;
    comp_done = 1'b0;
    raw_val = '0;
    data_ready = 1'b0;
    v_sample = 16'h0000;
    cal_done = 1'b0;
    cal_target = 8'h00;
    cal_pass = 1'b0;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int a = 0; a < 12; a += 4) begin
      acc(1'b0, 8'(a), 32'h0);
      chk(rd, 32'h0, "reset value");
    end
    chk({30'h0, alert_a, alert_b}, 32'h0, "pins at reset");
    $display("test reset done");
    acc(1'b1, osep_pkg::OFF_SHIFT_A, 32'hFFFF_FFFF);
    acc(1'b0, osep_pkg::OFF_SHIFT_A, 32'h0);
    chk(rd, 32'h00FF_FFFF, "range a fields");
    acc(1'b1, osep_pkg::OFF_SHIFT_B, 32'hFFFF_FFFF);
    acc(1'b0, osep_pkg::OFF_SHIFT_B, 32'h0);
    chk(rd, 32'h00FF_FF00, "range b fields");
    acc(1'b0, 8'hFC, 32'h0);
    chk({rd[30:0], err}, 32'h1, "unmapped read");
    $display("test fields done");
    for (int i = 0; i < 6; i++) begin
      // counts below 16 keep every output in range
      v = $random(seed) & 15;
      c1 = $random(seed) & 15;
      c2 = $random(seed) & 15;
      p1 = $random(seed) & 15;
      p2 = $random(seed) & 15;
      acc(1'b1, osep_pkg::OFF_SHIFT_A, {8'h00, 8'(p1), 8'(c1), 8'(v)});
      acc(1'b1, osep_pkg::OFF_SHIFT_B, {8'h00, 8'(p2), 8'(c2), 8'h00});
      for (int k = 0; k < 7; k++) rv[k] = $random(seed);
      sh = '{v, c1, c2, p1, p1, p2, p2};
      comp(rv);
      for (int k = 0; k < 7; k++) begin
        s = rv[k];
        if (k > 2) e = s >>> sh[k];
        else e = rv[k] >> sh[k];
        chk(out_val[k], e, "scaled output");
      end
    end
    $display("test scaling done");
    acc(1'b1, osep_pkg::OFF_SHIFT_A, 32'h0000_0100);
    acc(1'b1, osep_pkg::OFF_SHIFT_B, 32'h0);
    acc(1'b1, osep_pkg::OFF_LIMIT0 + 8'h08, 32'd100);
    acc(1'b1, osep_pkg::OFF_LIMIT0 + 8'h0C, 32'd50);
    // conditions left over from the scaling test must be re-evaluated
    rv = '0;
    comp(rv);
    acc(1'b1, osep_pkg::OFF_EVCFG, 32'h0000_C000);
    pins(1'b1, 1'b1);
    acc(1'b1, osep_pkg::OFF_EVCFG, 32'h0004_C000);
    pins(1'b0, 1'b1);
    rv = '0;
    rv[1] = 32'd202;
    comp(rv);
    pins(1'b1, 1'b1);
    acc(1'b0, osep_pkg::OFF_EVSTAT, 32'h0);
    chk(rd, 32'h0000_0044, "status over-current");
    rv[1] = 32'd200;
    comp(rv);
    pins(1'b0, 1'b1);
    acc(1'b1, osep_pkg::OFF_EVCFG, 32'h000C_0000);
    rv[1] = 32'd0;
    rv[3] = 32'd500;
    comp(rv);
    pins(1'b1, 1'b0);
    acc(1'b1, osep_pkg::OFF_EVCFG, 32'h0004_0010);
    rv = '0;
    rv[1] = 32'd202;
    comp(rv);
    rv[1] = 32'd0;
    comp(rv);
    pins(1'b1, 1'b0);
    acc(1'b1, osep_pkg::OFF_EVCFG, 32'h0004_0810);
    pins(1'b0, 1'b0);
    // simulated over-current routed to pin a, manual high on pin b
    acc(1'b1, osep_pkg::OFF_EVCFG, 32'h0004_C2A1);
    pins(1'b1, 1'b1);
    acc(1'b0, osep_pkg::OFF_EVCFG, 32'h0);
    chk(rd, 32'h0004_C0A1, "event config readback");
    $display("test event pins done");
    acc(1'b1, osep_pkg::OFF_LIMIT0, 32'd100);
    acc(1'b1, osep_pkg::OFF_LIMIT0 + 8'h04, 32'd500000);
    acc(1'b1, osep_pkg::OFF_EVCFG, 32'h0030_0000);
    for (int i = 0; i < 9; i++) begin
      samp((i < 4) ? 16'd1000 : 16'd0);
      m = 0;
      foreach (sq[j]) m += sq[j];
      m = m / 4;
      acc(1'b0, osep_pkg::OFF_MSQ, 32'h0);
      chk(rd, 32'(m), "mean square");
      pins(1'b0, (m > 500000) || (m < 100));
    end
    $display("test sag surge done");
    cal(8'h05, 1'b0);
    acc(1'b0, osep_pkg::OFF_EVCFG, 32'h0);
    chk(rd, 32'h0530_0000, "calibration failed bits");
    cal(8'h01, 1'b1);
    acc(1'b0, osep_pkg::OFF_EVCFG, 32'h0);
    chk(rd, 32'h0430_0000, "calibration pass clears");
    $display("test calibration done");
    final_report();
  end
endmodule : output_scaling_and_event_pins_tb
